// *** hdl/t1lt_defines.svh ***
`ifndef T1LT_DEFINES_SVH
`define T1LT_DEFINES_SVH
// clock and line rates in kHz, used by the fractional bit-rate divider
`define T1LT_CLK_KHZ      125000
`define T1LT_LINE_KHZ     1544
// frame layout: 24 channel slots of 8 bits after one framing bit
`define T1LT_CH_LAST      5'h17
`define T1LT_BIT_LAST     3'h7
`define T1LT_D4_LAST      5'h0B
`define T1LT_ESF_LAST     5'h17
`define T1LT_D4_FBITS     12'h8DC
`define T1LT_ESF_FAS      6'h0B
// one-in-eight pattern: position of the single mark in each byte
`define T1LT_ONE_IN_8_POS 3'h1
// self test and one-second error window
`define T1LT_RAM_SEED     8'hA5
`define T1LT_ROM_SUM      8'hF8
`define T1LT_ONE_SEC_MS   1000
`define T1LT_LED_TEST_MS  500
`endif

// *** hdl/t1lt_pkg.sv ***
package t1lt_pkg;
  // bipolar line code of one bit time
  typedef struct packed {
    logic pos;
    logic neg;
  } t1lt_line_t;
  // network receive: line code, decoded bit, framing bit marker
  typedef struct packed {
    t1lt_line_t code;
    logic       data;
    logic       fbit;
  } t1lt_rx_t;
  typedef enum logic [1:0] {LOOP_NONE, LOOP_LINE, LOOP_PAYLOAD} t1lt_loop_t;
  typedef enum logic [1:0] {PAT_NONE, PAT_ONES, PAT_ZEROS, PAT_ONE_IN_8} t1lt_pat_t;
  typedef enum logic [2:0] {ST_RAM_WR, ST_RAM_RD, ST_ROM, ST_LED, ST_INIT, ST_RUN} t1lt_st_t;
endpackage : t1lt_pkg

// *** hdl/t1lt_fifo.sv ***
`timescale 1ns/1ps
module t1lt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign o_in_ready  = (cnt_r != FULL);
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rp_r];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // pointers wrap naturally since depth is a power of two
  always_comb
  begin
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    if (i_flush)
    begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset
  always_ff @(posedge i_clock)
  begin
    if (push)
      mem_r[wp_r] <= i_in_data;
  end
endmodule : t1lt_fifo

// *** hdl/t1lt_top.sv ***
// How it works
// - line loopback returns network receive to network
// - line loopback copies received line code exactly
// - payload loopback regenerates framing, returns payload only
// - terminal loopback returns terminal receive to terminal
// - three patterns: ones, zeros, one-in-eight
// - ones pattern sets every payload bit
// - zeros pattern clears every payload bit
// - one-in-eight: one mark per channel byte
// - inband and data link commands switch loopbacks
// - error light on if error within last second
// - alarm light follows any alarm condition
// - loop light for own or commanded remote loopback
// - power-up runs self test then initialisation
// - memory, checksum, then light test; report failures
// - frame holds one framing bit then 24 eight-bit channel slots
// - self test sends framed ones to network, unframed ones to terminal
`timescale 1ns/1ps
`include "t1lt_defines.svh"
module t1lt_top #(
  parameter int ONE_SEC_CYCLES  = `T1LT_ONE_SEC_MS * `T1LT_CLK_KHZ,
  parameter int LED_TEST_CYCLES = `T1LT_LED_TEST_MS * `T1LT_CLK_KHZ
) (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_n,
  input  wire t1lt_pkg::t1lt_rx_t   i_net_rx,
  input  wire t1lt_pkg::t1lt_line_t i_term_rx,
  input  wire logic                 i_esf_mode,
  input  wire t1lt_pkg::t1lt_loop_t i_loop_sel,
  input  wire logic                 i_loop_sel_stb,
  input  wire logic                 i_inband_up,
  input  wire logic                 i_inband_down,
  input  wire logic                 i_fdl_line_up,
  input  wire logic                 i_fdl_payload_up,
  input  wire logic                 i_fdl_down,
  input  wire logic                 i_term_loop,
  input  wire t1lt_pkg::t1lt_pat_t  i_pattern,
  input  wire logic                 i_remote_lb_active,
  input  wire logic                 i_err_event,
  input  wire logic                 i_alarm,
  input  wire logic                 i_selftest_req,
  output t1lt_pkg::t1lt_line_t      o_net_tx,
  output t1lt_pkg::t1lt_line_t      o_term_tx,
  output t1lt_pkg::t1lt_loop_t      o_loop_state,
  output logic                      o_term_loop,
  output logic                      o_led_error,
  output logic                      o_led_alarm,
  output logic                      o_led_loop,
  output logic                      o_selftest_busy,
  output logic [1:0]                o_selftest_fail,
  output logic                      o_fifo_slip
);
  localparam logic [16:0] CLK_KHZ  = 17'(`T1LT_CLK_KHZ);
  localparam logic [16:0] LINE_KHZ = 17'(`T1LT_LINE_KHZ);
  localparam logic [11:0] D4_PAT   = `T1LT_D4_FBITS;
  localparam logic [5:0]  ESF_PAT  = `T1LT_ESF_FAS;

  // ami encoder: marks alternate polarity
  function automatic t1lt_pkg::t1lt_line_t ami(input logic mark, input logic pol);
    ami.pos = mark & ~pol;
    ami.neg = mark & pol;
  endfunction : ami

  // fixed program-store image for the checksum step
  function automatic logic [7:0] rom(input logic [3:0] a);
    rom = {a, ~a};
  endfunction : rom

  // bit-rate enable: fractional divider from 125 MHz to 1.544 MHz
  logic [16:0] acc_r, acc_nxt, acc_sum;
  logic        tick_r, tick_nxt;
  always_comb
  begin
    acc_sum  = acc_r + LINE_KHZ;
    tick_nxt = (acc_sum >= CLK_KHZ);
    acc_nxt  = tick_nxt ? acc_sum - CLK_KHZ : acc_sum;
  end
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      acc_r  <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      acc_r  <= acc_nxt;
      tick_r <= tick_nxt;
    end
  end

  // self test and initialisation sequencer
  t1lt_pkg::t1lt_st_t st_r, st_nxt;
  logic [3:0]  idx_r, idx_nxt;
  logic [7:0]  sum_r, sum_nxt;
  logic [1:0]  fail_r, fail_nxt;
  logic [31:0] led_cnt_r, led_cnt_nxt;
  logic [7:0]  ram_r [16];
  logic [7:0]  ram_pat;
  logic        ram_we, busy_nxt, init_pulse;
  always_comb
  begin
    st_nxt      = st_r;
    idx_nxt     = idx_r;
    sum_nxt     = sum_r;
    fail_nxt    = fail_r;
    led_cnt_nxt = led_cnt_r;
    ram_pat     = {4'h0, idx_r} ^ `T1LT_RAM_SEED;
    ram_we      = 1'b0;
    init_pulse  = 1'b0;
    unique case (st_r)
      t1lt_pkg::ST_RAM_WR:
      begin
        ram_we  = 1'b1;
        idx_nxt = idx_r + 4'h1;
        if (idx_r == 4'hF)
          st_nxt = t1lt_pkg::ST_RAM_RD;
      end
      t1lt_pkg::ST_RAM_RD:
      begin
        if (ram_r[idx_r] != ram_pat)
          fail_nxt[0] = 1'b1;
        idx_nxt = idx_r + 4'h1;
        if (idx_r == 4'hF)
          st_nxt = t1lt_pkg::ST_ROM;
      end
      t1lt_pkg::ST_ROM:
      begin
        sum_nxt = sum_r + rom(idx_r);
        idx_nxt = idx_r + 4'h1;
        if (idx_r == 4'hF)
        begin
          st_nxt = t1lt_pkg::ST_LED;
          if (sum_nxt != `T1LT_ROM_SUM)
            fail_nxt[1] = 1'b1;
        end
      end
      t1lt_pkg::ST_LED:
      begin
        led_cnt_nxt = led_cnt_r + 32'h1;
        if (led_cnt_r == 32'(LED_TEST_CYCLES - 1))
          st_nxt = t1lt_pkg::ST_INIT;
      end
      t1lt_pkg::ST_INIT:
      begin
        init_pulse = 1'b1;
        st_nxt     = t1lt_pkg::ST_RUN;
      end
      t1lt_pkg::ST_RUN:
      begin
        if (i_selftest_req)
        begin
          st_nxt      = t1lt_pkg::ST_RAM_WR;
          fail_nxt    = 2'h0;
          sum_nxt     = 8'h00;
          led_cnt_nxt = 32'h0;
          idx_nxt     = 4'h0;
        end
      end
    endcase
    busy_nxt = (st_nxt != t1lt_pkg::ST_RUN);
  end
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r      <= t1lt_pkg::ST_RAM_WR;
      idx_r     <= 4'h0;
      sum_r     <= 8'h00;
      fail_r    <= 2'h0;
      led_cnt_r <= 32'h0;
    end
    else
    begin
      st_r      <= st_nxt;
      idx_r     <= idx_nxt;
      sum_r     <= sum_nxt;
      fail_r    <= fail_nxt;
      led_cnt_r <= led_cnt_nxt;
    end
  end
  always_ff @(posedge i_clock)
  begin
    if (ram_we)
      ram_r[idx_r] <= ram_pat;
  end

  // loopback control: latest command wins, one network loop at a time
  t1lt_pkg::t1lt_loop_t loop_r, loop_nxt;
  logic term_loop_r, term_loop_nxt;
  always_comb
  begin
    loop_nxt      = loop_r;
    term_loop_nxt = i_term_loop & ~busy_nxt;
    if (init_pulse || busy_nxt)
      loop_nxt = t1lt_pkg::LOOP_NONE;
    else if (i_fdl_down || i_inband_down)
      loop_nxt = t1lt_pkg::LOOP_NONE;
    else if (i_fdl_payload_up)
      loop_nxt = t1lt_pkg::LOOP_PAYLOAD;
    else if (i_fdl_line_up || i_inband_up)
      loop_nxt = t1lt_pkg::LOOP_LINE;
    else if (i_loop_sel_stb)
      loop_nxt = i_loop_sel;
  end
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      loop_r      <= t1lt_pkg::LOOP_NONE;
      term_loop_r <= 1'b0;
    end
    else
    begin
      loop_r      <= loop_nxt;
      term_loop_r <= term_loop_nxt;
    end
  end

  // transmit frame position: framing bit, then 24 channels of 8 bits
  logic       fpos_r, fpos_nxt;
  logic [4:0] ch_r, ch_nxt, frm_r, frm_nxt, frm_last;
  logic [2:0] bit_r, bit_nxt;
  logic       fbit;
  always_comb
  begin
    fpos_nxt = fpos_r;
    ch_nxt   = ch_r;
    bit_nxt  = bit_r;
    frm_nxt  = frm_r;
    frm_last = i_esf_mode ? `T1LT_ESF_LAST : `T1LT_D4_LAST;
    if (tick_r)
    begin
      if (fpos_r)
      begin
        fpos_nxt = 1'b0;
        ch_nxt   = 5'h00;
        bit_nxt  = 3'h0;
      end
      else if (bit_r == `T1LT_BIT_LAST)
      begin
        bit_nxt = 3'h0;
        ch_nxt  = ch_r + 5'h01;
        if (ch_r == `T1LT_CH_LAST)
        begin
          fpos_nxt = 1'b1;
          frm_nxt  = (frm_r >= frm_last) ? 5'h00 : frm_r + 5'h01;
        end
      end
      else
        bit_nxt = bit_r + 3'h1;
    end
    // framing pattern regenerated in the configured format
    if (i_esf_mode)
      fbit = (frm_r[1:0] == 2'h3) ? ESF_PAT[3'h5 - frm_r[4:2]] : 1'b1;
    else
      fbit = D4_PAT[4'hB - frm_r[3:0]];
  end
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fpos_r <= 1'b1;
      ch_r   <= 5'h00;
      bit_r  <= 3'h0;
      frm_r  <= 5'h00;
    end
    else
    begin
      fpos_r <= fpos_nxt;
      ch_r   <= ch_nxt;
      bit_r  <= bit_nxt;
      frm_r  <= frm_nxt;
    end
  end

  // payload loop: collect receive payload bytes, framing bits dropped
  logic       pl_on, in_valid_r, in_valid_nxt, in_ready, out_valid, out_ready;
  logic [7:0] sh_r, sh_nxt, in_byte_r, in_byte_nxt, out_byte, tx_byte_r, tx_byte_nxt;
  logic [2:0] rxc_r, rxc_nxt;
  logic       slip_r, slip_nxt;
  assign pl_on = (loop_r == t1lt_pkg::LOOP_PAYLOAD);
  always_comb
  begin
    sh_nxt       = sh_r;
    rxc_nxt      = rxc_r;
    in_byte_nxt  = in_byte_r;
    in_valid_nxt = in_valid_r & ~in_ready;
    slip_nxt     = slip_r & pl_on;
    if (tick_r && pl_on && !i_net_rx.fbit)
    begin
      if (in_valid_r && !in_ready)
        slip_nxt = 1'b1;                                   // fifo full stalls assembly
      else
      begin
        sh_nxt  = {sh_r[6:0], i_net_rx.data};
        rxc_nxt = rxc_r + 3'h1;
        if (rxc_r == `T1LT_BIT_LAST)
        begin
          in_byte_nxt  = {sh_r[6:0], i_net_rx.data};
          in_valid_nxt = 1'b1;
        end
      end
    end
    if (!pl_on)
    begin
      rxc_nxt      = 3'h0;
      in_valid_nxt = 1'b0;
    end
    // transmit side drains one byte at each channel start
    out_ready   = tick_r & pl_on & ~fpos_r & (bit_r == 3'h0);
    tx_byte_nxt = tx_byte_r;
    if (out_ready)
      tx_byte_nxt = out_valid ? out_byte : 8'hFF;          // idle ones on underrun
  end
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sh_r       <= 8'h00;
      rxc_r      <= 3'h0;
      in_byte_r  <= 8'h00;
      in_valid_r <= 1'b0;
      slip_r     <= 1'b0;
      tx_byte_r  <= 8'hFF;
    end
    else
    begin
      sh_r       <= sh_nxt;
      rxc_r      <= rxc_nxt;
      in_byte_r  <= in_byte_nxt;
      in_valid_r <= in_valid_nxt;
      slip_r     <= slip_nxt;
      tx_byte_r  <= tx_byte_nxt;
    end
  end

  t1lt_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_flush     (~pl_on),
    .i_in_valid  (in_valid_r),
    .o_in_ready  (in_ready),
    .i_in_data   (in_byte_r),
    .o_out_valid (out_valid),
    .i_out_ready (out_ready),
    .o_out_data  (out_byte)
  );

  // transmit selection toward both lines
  t1lt_pkg::t1lt_line_t net_tx_r, net_tx_nxt, term_tx_r, term_tx_nxt;
  logic pol_net_r, pol_net_nxt, pol_term_r, pol_term_nxt, mark, gen;
  always_comb
  begin
    net_tx_nxt   = net_tx_r;
    term_tx_nxt  = term_tx_r;
    pol_net_nxt  = pol_net_r;
    pol_term_nxt = pol_term_r;
    gen          = 1'b0;
    // payload bit choice; framing bit regenerated whenever gen is set
    if (fpos_r)
      mark = fbit;
    else if (busy_nxt)
      mark = 1'b1;
    else if (pl_on)
      mark = (bit_r == 3'h0) ? tx_byte_nxt[7] : tx_byte_r[3'h7 - bit_r];
    else
      unique case (i_pattern)
        t1lt_pkg::PAT_ONES:     mark = 1'b1;
        t1lt_pkg::PAT_ZEROS:    mark = 1'b0;
        t1lt_pkg::PAT_ONE_IN_8: mark = (bit_r == `T1LT_ONE_IN_8_POS);
        t1lt_pkg::PAT_NONE:     mark = 1'b0;
      endcase
    if (tick_r)
    begin
      if (busy_nxt || pl_on || (loop_r == t1lt_pkg::LOOP_NONE
          && i_pattern != t1lt_pkg::PAT_NONE))
        gen = 1'b1;
      if (loop_r == t1lt_pkg::LOOP_LINE && !busy_nxt)
        net_tx_nxt = i_net_rx.code;
      else if (gen)
      begin
        net_tx_nxt  = ami(mark, pol_net_r);
        pol_net_nxt = pol_net_r ^ mark;
      end
      else
        net_tx_nxt = i_term_rx;
      if (busy_nxt)
      begin
        term_tx_nxt  = ami(1'b1, pol_term_r);
        pol_term_nxt = ~pol_term_r;
      end
      else if (term_loop_r)
        term_tx_nxt = i_term_rx;
      else
        term_tx_nxt = i_net_rx.code;
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      net_tx_r   <= '0;
      term_tx_r  <= '0;
      pol_net_r  <= 1'b0;
      pol_term_r <= 1'b0;
    end
    else
    begin
      net_tx_r   <= net_tx_nxt;
      term_tx_r  <= term_tx_nxt;
      pol_net_r  <= pol_net_nxt;
      pol_term_r <= pol_term_nxt;
    end
  end

  // indicators: error seen in current or previous second
  logic [31:0] sec_r, sec_nxt;
  logic err_cur_r, err_cur_nxt, err_prev_r, err_prev_nxt;
  logic led_err_r, led_err_nxt, led_alm_r, led_alm_nxt, led_lp_r, led_lp_nxt;
  logic led_test;
  always_comb
  begin
    led_test     = (st_r == t1lt_pkg::ST_LED);
    sec_nxt      = sec_r + 32'h1;
    err_cur_nxt  = err_cur_r | i_err_event;
    err_prev_nxt = err_prev_r;
    if (sec_r == 32'(ONE_SEC_CYCLES - 1))
    begin
      sec_nxt      = 32'h0;
      err_prev_nxt = err_cur_r | i_err_event;
      err_cur_nxt  = 1'b0;
    end
    led_err_nxt = led_test | err_cur_nxt | err_prev_nxt;
    led_alm_nxt = led_test | i_alarm;
    led_lp_nxt  = led_test | (loop_nxt != t1lt_pkg::LOOP_NONE) | term_loop_nxt
                | i_remote_lb_active;
  end
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sec_r      <= 32'h0;
      err_cur_r  <= 1'b0;
      err_prev_r <= 1'b0;
      led_err_r  <= 1'b0;
      led_alm_r  <= 1'b0;
      led_lp_r   <= 1'b0;
    end
    else
    begin
      sec_r      <= sec_nxt;
      err_cur_r  <= err_cur_nxt;
      err_prev_r <= err_prev_nxt;
      led_err_r  <= led_err_nxt;
      led_alm_r  <= led_alm_nxt;
      led_lp_r   <= led_lp_nxt;
    end
  end

  // status flops straight to the ports
  logic busy_r;
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      busy_r <= 1'b1;
    else
      busy_r <= busy_nxt;
  end

  assign o_net_tx        = net_tx_r;
  assign o_term_tx       = term_tx_r;
  assign o_loop_state    = loop_r;
  assign o_term_loop     = term_loop_r;
  assign o_led_error     = led_err_r;
  assign o_led_alarm     = led_alm_r;
  assign o_led_loop      = led_lp_r;
  assign o_selftest_busy = busy_r;
  assign o_selftest_fail = fail_r;
  assign o_fifo_slip     = slip_r;
endmodule : t1lt_top

// *** test/t1lt_top_props.sv ***
`timescale 1ns/1ps
module t1lt_top_props (
  input wire logic                 i_clock,
  input wire logic                 i_rst_n,
  input wire t1lt_pkg::t1lt_rx_t   i_net_rx,
  input wire t1lt_pkg::t1lt_line_t i_term_rx,
  input wire logic                 i_fdl_line_up,
  input wire logic                 i_fdl_payload_up,
  input wire logic                 i_fdl_down,
  input wire logic                 i_inband_down,
  input wire logic                 i_selftest_req,
  input wire logic                 i_err_event,
  input wire logic                 i_alarm,
  input wire t1lt_pkg::t1lt_line_t o_net_tx,
  input wire t1lt_pkg::t1lt_line_t o_term_tx,
  input wire t1lt_pkg::t1lt_loop_t o_loop_state,
  input wire logic                 o_term_loop,
  input wire logic                 o_led_error,
  input wire logic                 o_led_alarm,
  input wire logic                 o_led_loop,
  input wire logic                 o_selftest_busy,
  input wire logic                 o_fifo_slip
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  // command levels that the unit is free to obey, and a line loop seen now and three cycles back
  sequence free_s;
    !o_selftest_busy && !i_selftest_req;
  endsequence
  sequence down_s;
    (i_fdl_down || i_inband_down) ##0 free_s;
  endsequence
  sequence line_held_s;
    o_loop_state == t1lt_pkg::LOOP_LINE && $past(o_loop_state, 3) == t1lt_pkg::LOOP_LINE;
  endsequence
  // loop command answers
  loop_down_a: assert property (
    down_s |=> o_loop_state == t1lt_pkg::LOOP_NONE) else $error("loop not released");
  payload_up_a: assert property (
    (i_fdl_payload_up && !i_fdl_down && !i_inband_down) ##0 free_s
    |=> o_loop_state == t1lt_pkg::LOOP_PAYLOAD) else $error("payload loop not entered");
  line_up_a: assert property (
    (i_fdl_line_up && !i_fdl_payload_up && !i_fdl_down && !i_inband_down) ##0 free_s
    |=> o_loop_state == t1lt_pkg::LOOP_LINE) else $error("line loop not entered");
  busy_noloop_a: assert property (
    o_selftest_busy && $past(o_selftest_busy) |-> o_loop_state == t1lt_pkg::LOOP_NONE)
    else $error("loop active during self test");
  // indicator lights
  loop_led_a: assert property (
    o_loop_state != t1lt_pkg::LOOP_NONE |-> o_led_loop) else $error("loop light dark");
  alarm_on_a: assert property (
    i_alarm && !o_selftest_busy |-> ##[1:2] o_led_alarm) else $error("alarm light dark");
  alarm_off_a: assert property (
    (!i_alarm && !o_selftest_busy) [*3] |-> !o_led_alarm) else $error("alarm light stuck");
  error_on_a: assert property (
    i_err_event && !o_selftest_busy |-> ##[1:2] o_led_error) else $error("error light dark");
  // loop data copies and slip flag
  line_copy_a: assert property (
    line_held_s ##0 $changed(o_net_tx)
    |-> o_net_tx == $past(i_net_rx.code) || o_net_tx == $past(i_net_rx.code, 2))
    else $error("line loop data differs");
  term_copy_a: assert property (
    o_term_loop && $past(o_term_loop, 3) && $changed(o_term_tx)
    |-> o_term_tx == $past(i_term_rx) || o_term_tx == $past(i_term_rx, 2))
    else $error("terminal loop data differs");
  slip_clear_a: assert property (
    o_loop_state != t1lt_pkg::LOOP_PAYLOAD && $past(o_loop_state) != t1lt_pkg::LOOP_PAYLOAD
    |-> !o_fifo_slip) else $error("slip flag outside payload loop");
endmodule : t1lt_top_props

bind t1lt_top t1lt_top_props u_props (.i_clock, .i_rst_n, .i_net_rx, .i_term_rx,
  .i_fdl_line_up, .i_fdl_payload_up, .i_fdl_down, .i_inband_down, .i_selftest_req,
  .i_err_event, .i_alarm, .o_net_tx, .o_term_tx, .o_loop_state, .o_term_loop,
  .o_led_error, .o_led_alarm, .o_led_loop, .o_selftest_busy, .o_fifo_slip);

// *** test/t1lt_line_partner.sv ***
`timescale 1ns/1ps
module t1lt_line_partner #(
  parameter int BIT_CLKS = 81
) (
  input  wire logic                 i_clock,
  input  wire t1lt_pkg::t1lt_line_t i_net_code,
  input  wire t1lt_pkg::t1lt_line_t i_term_code,
  output t1lt_pkg::t1lt_rx_t        o_net_rx,
  output t1lt_pkg::t1lt_line_t      o_term_rx
);
  int clk_cnt = 0;
  int bit_cnt = 0;
  // lines start quiet
  initial
  begin
    o_net_rx  = 4'h0;
    o_term_rx = 2'h0;
  end
  // one bit per line period, framing bit every 193 bits
  always @(posedge i_clock)
  begin
    clk_cnt <= (clk_cnt == BIT_CLKS - 1) ? 0 : clk_cnt + 1;
    if (clk_cnt == 0)
    begin
      bit_cnt       <= (bit_cnt == 192) ? 0 : bit_cnt + 1;
      o_net_rx.code <= i_net_code;
      o_net_rx.data <= i_net_code.pos | i_net_code.neg;
      o_net_rx.fbit <= (bit_cnt == 0);
      o_term_rx     <= i_term_code; // terminal side sources its own pattern
    end
  end
endmodule : t1lt_line_partner

// *** test/tb_t1lt_top.sv ***
`timescale 1ns/1ps
module tb_t1lt_top;
  logic                 i_clock   = 1'b0;
  logic                 i_rst_n   = 1'b0;
  t1lt_pkg::t1lt_rx_t   net_rx;
  t1lt_pkg::t1lt_line_t term_rx, net_tx, term_tx;
  t1lt_pkg::t1lt_line_t net_code  = 2'h0;
  t1lt_pkg::t1lt_line_t term_code = 2'h0;
  t1lt_pkg::t1lt_loop_t loop_sel  = t1lt_pkg::LOOP_PAYLOAD;
  t1lt_pkg::t1lt_loop_t loop_st;
  t1lt_pkg::t1lt_pat_t  pattern   = t1lt_pkg::PAT_NONE;
  logic [5:0]           cmd_v     = 6'h00;
  logic                 esf = 1'b0, term_loop = 1'b0, remote = 1'b0, err_ev = 1'b0;
  logic                 alarm = 1'b0, st_req = 1'b0;
  logic                 term_loop_o, led_err, led_alm, led_loop, busy, slip;
  logic [1:0]           fail;
  int                   n_mismatch = 0;
  int                   n_checks   = 0;

  t1lt_top #(.ONE_SEC_CYCLES(100), .LED_TEST_CYCLES(8)) dut (
    .i_clock, .i_rst_n, .i_net_rx(net_rx), .i_term_rx(term_rx), .i_esf_mode(esf),
    .i_loop_sel(loop_sel), .i_loop_sel_stb(cmd_v[5]), .i_inband_up(cmd_v[3]),
    .i_inband_down(cmd_v[4]), .i_fdl_line_up(cmd_v[0]), .i_fdl_payload_up(cmd_v[1]),
    .i_fdl_down(cmd_v[2]), .i_term_loop(term_loop), .i_pattern(pattern),
    .i_remote_lb_active(remote), .i_err_event(err_ev), .i_alarm(alarm),
    .i_selftest_req(st_req), .o_net_tx(net_tx), .o_term_tx(term_tx),
    .o_loop_state(loop_st), .o_term_loop(term_loop_o), .o_led_error(led_err),
    .o_led_alarm(led_alm), .o_led_loop(led_loop), .o_selftest_busy(busy),
    .o_selftest_fail(fail), .o_fifo_slip(slip));
  t1lt_line_partner partner (.i_clock, .i_net_code(net_code), .i_term_code(term_code),
    .o_net_rx(net_rx), .o_term_rx(term_rx));

  // 125 MHz clock
  initial
  begin
    forever #4 i_clock = ~i_clock;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // bounded wait: 0 network tx, 1 terminal tx, 2 busy flag
  task automatic wait_on(input int m, input logic [1:0] exp);
    logic [1:0] got;
    n_checks++;
    for (int i = 0; i < 400; i++)
    begin
      @(posedge i_clock);
      #1;
      got = (m == 0) ? net_tx : (m == 1) ? term_tx : {1'b0, busy};
      if (got === exp)
        return;
    end
    $display("unexpected wait %0d: expected %h, seen %h", m, exp, got);
    n_mismatch++;
    complete_run();
  endtask : wait_on

  task automatic cmd(input logic [5:0] v, input t1lt_pkg::t1lt_loop_t exp);
    @(posedge i_clock);
    cmd_v <= v;
    @(posedge i_clock);
    cmd_v <= 6'h00;
    #1;
    chk("loop_state", {6'h00, exp}, {6'h00, loop_st});
    if (!busy)
      chk("led_loop", {7'h00, exp != t1lt_pkg::LOOP_NONE}, {7'h00, led_loop});
  endtask : cmd

  task automatic t_selftest();
    logic lit;
    lit = 1'b0;
    chk("busy_in_reset", 8'h01, {7'h00, busy});
    @(posedge i_clock);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 200 && busy !== 1'b0; i++)
    begin
      @(posedge i_clock);
      #1;
      lit = lit | (led_err & led_alm & led_loop);
    end
    chk("busy_done", 8'h00, {7'h00, busy});
    if (busy !== 1'b0)
      complete_run();
    chk("led_test", 8'h01, {7'h00, lit});
    chk("fail", 8'h00, {6'h00, fail});
  endtask : t_selftest

  task automatic t_loops();
    logic [5:0]           v [8] = '{6'h01, 6'h10, 6'h02, 6'h08, 6'h20, 6'h04, 6'h03, 6'h05};
    t1lt_pkg::t1lt_loop_t e [8] = '{t1lt_pkg::LOOP_LINE, t1lt_pkg::LOOP_NONE,
      t1lt_pkg::LOOP_PAYLOAD, t1lt_pkg::LOOP_LINE, t1lt_pkg::LOOP_PAYLOAD,
      t1lt_pkg::LOOP_NONE, t1lt_pkg::LOOP_PAYLOAD, t1lt_pkg::LOOP_NONE};
    foreach (v[i])
      cmd(v[i], e[i]);
  endtask : t_loops

  task automatic t_line();
    net_code <= 2'h3; // bipolar violation on the receive line
    cmd(6'h01, t1lt_pkg::LOOP_LINE);
    wait_on(0, 2'h3);
    net_code <= 2'h1;
    wait_on(0, 2'h1);
    term_code <= 2'h2;
    cmd(6'h04, t1lt_pkg::LOOP_NONE);
    wait_on(0, 2'h2);
    term_code <= 2'h0;
  endtask : t_line

  task automatic t_term();
    @(posedge i_clock);
    term_loop <= 1'b1;
    term_code <= 2'h2;
    wait_on(1, 2'h2);
    chk("term_loop", 8'h01, {7'h00, term_loop_o});
    term_code <= 2'h3;
    wait_on(1, 2'h3);
    @(posedge i_clock);
    term_loop <= 1'b0;
    term_code <= 2'h0;
  endtask : t_term

  // count marks over one frame of bit times and check their polarity
  task automatic t_pat(input t1lt_pkg::t1lt_pat_t p, input int lo, input int hi);
    int                   marks = 0;
    int                   bad   = 0;
    t1lt_pkg::t1lt_line_t prev  = 2'h0;
    t1lt_pkg::t1lt_line_t last  = 2'h0;
    @(posedge i_clock);
    pattern <= p;
    repeat (400) @(posedge i_clock);
    for (int i = 0; i < 15625; i++)
    begin
      @(posedge i_clock);
      #1;
      if (net_tx !== prev && net_tx !== 2'h0)
      begin
        marks++;
        if (net_tx === last || net_tx === 2'h3)
          bad++;
        last = net_tx;
      end
      prev = net_tx;
    end
    chk("mark_count_ok", 8'h01, {7'h00, marks >= lo && marks <= hi});
    chk("ami_alternation", 8'h00, bad[7:0]);
  endtask : t_pat

  task automatic t_leds();
    @(posedge i_clock);
    err_ev <= 1'b1;
    alarm <= 1'b1;
    remote <= 1'b1;
    @(posedge i_clock);
    err_ev <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1;
    chk("led_error", 8'h01, {7'h00, led_err});
    chk("led_alarm", 8'h01, {7'h00, led_alm});
    chk("led_loop", 8'h01, {7'h00, led_loop});
    @(posedge i_clock);
    alarm <= 1'b0;
    remote <= 1'b0;
    repeat (87) @(posedge i_clock);
    #1;
    chk("led_error", 8'h01, {7'h00, led_err});
    chk("led_alarm", 8'h00, {7'h00, led_alm});
    chk("led_loop", 8'h00, {7'h00, led_loop});
    repeat (120) @(posedge i_clock);
    #1;
    chk("led_error", 8'h00, {7'h00, led_err});
  endtask : t_leds

  task automatic t_refuse();
    cmd(6'h01, t1lt_pkg::LOOP_LINE);
    @(posedge i_clock);
    st_req <= 1'b1;
    @(posedge i_clock);
    st_req <= 1'b0;
    cmd(6'h01, t1lt_pkg::LOOP_NONE);
    chk("busy", 8'h01, {7'h00, busy});
    wait_on(2, 2'h0);
    chk("fail", 8'h00, {6'h00, fail});
    chk("loop_after", 8'h00, {6'h00, loop_st});
  endtask : t_refuse

  // main sequence
  initial
  begin
    repeat (2) @(posedge i_clock);
    t_selftest();
    t_loops();
    t_line();
    t_term();
    t_pat(t1lt_pkg::PAT_ONES, 189, 194);
    t_pat(t1lt_pkg::PAT_ZEROS, 0, 2);
    esf <= 1'b1;
    t_pat(t1lt_pkg::PAT_ONE_IN_8, 23, 27);
    net_code <= 2'h0;
    cmd(6'h02, t1lt_pkg::LOOP_PAYLOAD);
    t_pat(t1lt_pkg::PAT_ONES, 0, 40);
    cmd(6'h04, t1lt_pkg::LOOP_NONE);
    pattern <= t1lt_pkg::PAT_NONE;
    t_leds();
    t_refuse();
    complete_run();
  end
endmodule : tb_t1lt_top
